// ---- design/tap_controller.sv ----
/*
 * Boundary-scan test access port: controller, instruction register,
 * boundary, bypass and identification registers. Assumes scan pins are
 * asynchronous to clk and the test clock is far slower than clk.
 */
`timescale 1ns/1ns
module tap_controller
    import tap_pkg::*;
#(
    parameter logic [ID_W-1:0] ID_VALUE = 32'h0000_0001  // arbitrary value
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire scan_in_t         scanIn,
    output scan_out_t             scanOut,
    input  wire logic [BSR_W-1:0] pinSample,
    output logic      [BSR_W-1:0] pinDrive,
    output logic                  testMode,
    output logic                  outFloat,
    output tap_state_t            tapState
);
    // two-stage synchronisers for the scan pins
    scan_in_t syncA_ff, syncB_ff, nxt_syncA, nxt_syncB;
    logic     tckPrev_ff, nxt_tckPrev;
    logic     rise, fall;

    always_comb begin
        nxt_syncA   = scanIn;
        nxt_syncB   = syncA_ff;
        nxt_tckPrev = syncB_ff.tck;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA_ff   <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
            syncB_ff   <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
            tckPrev_ff <= 1'b0;
        end else begin
            syncA_ff   <= nxt_syncA;
            syncB_ff   <= nxt_syncB;
            tckPrev_ff <= nxt_tckPrev;
        end
    end

    // edges of test clock found on the second stage only
    assign rise = syncB_ff.tck & ~tckPrev_ff;
    assign fall = ~syncB_ff.tck & tckPrev_ff;

    // controller state
    tap_state_t state_ff, nxt_state;
    always_comb begin
        nxt_state = state_ff;
        if (rise) begin
            case (state_ff)
                TLR:  nxt_state = syncB_ff.tms ? TLR  : RTI;
                RTI:  nxt_state = syncB_ff.tms ? SDRS : RTI;
                SDRS: nxt_state = syncB_ff.tms ? SIRS : CDR;
                CDR:  nxt_state = syncB_ff.tms ? E1DR : SHDR;
                SHDR: nxt_state = syncB_ff.tms ? E1DR : SHDR;
                E1DR: nxt_state = syncB_ff.tms ? UDR  : PDR;
                PDR:  nxt_state = syncB_ff.tms ? E2DR : PDR;
                E2DR: nxt_state = syncB_ff.tms ? UDR  : SHDR;
                UDR:  nxt_state = syncB_ff.tms ? SDRS : RTI;
                SIRS: nxt_state = syncB_ff.tms ? TLR  : CIR;
                CIR:  nxt_state = syncB_ff.tms ? E1IR : SHIR;
                SHIR: nxt_state = syncB_ff.tms ? E1IR : SHIR;
                E1IR: nxt_state = syncB_ff.tms ? UIR  : PIR;
                PIR:  nxt_state = syncB_ff.tms ? E2IR : PIR;
                E2IR: nxt_state = syncB_ff.tms ? UIR  : SHIR;
                UIR:  nxt_state = syncB_ff.tms ? SDRS : RTI;
                default: nxt_state = TLR;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= TLR;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // scan registers: shift stages and shadow instruction
    logic [IR_W-1:0]  irShift_ff, nxt_irShift, ir_ff, nxt_ir;
    logic [BSR_W-1:0] bsrShift_ff, nxt_bsrShift, bsrHold_ff, nxt_bsrHold;
    logic [ID_W-1:0]  idShift_ff, nxt_idShift;
    logic             byp_ff, nxt_byp;
    logic             selBsr, selId;
    logic             tdoOut_ff, nxt_tdoOut, tdoOe_n_ff, nxt_tdoOe_n;
    logic             serialOut;

    // data register chosen by the current instruction
    always_comb begin
        // clamp holds the pins from the shadow stage, so bypass is in path
        selBsr = (ir_ff == OP_EXTEST) || (ir_ff == OP_SAMPLE);
        selId  = (ir_ff == OP_IDCODE);
    end

    // one register only in the serial path
    always_comb begin
        if (state_ff == SHIR) begin
            serialOut = irShift_ff[0];
        end else if (selBsr) begin
            serialOut = bsrShift_ff[0];
        end else if (selId) begin
            serialOut = idShift_ff[0];
        end else begin
            serialOut = byp_ff;
        end
    end

    // capture, shift and update on controller activity
    always_comb begin
        nxt_irShift  = irShift_ff;
        nxt_ir       = ir_ff;
        nxt_bsrShift = bsrShift_ff;
        nxt_bsrHold  = bsrHold_ff;
        nxt_idShift  = idShift_ff;
        nxt_byp      = byp_ff;
        nxt_tdoOut   = tdoOut_ff;
        nxt_tdoOe_n  = tdoOe_n_ff;
        if (state_ff == TLR) begin
            nxt_ir                  = IR_RESET;
            nxt_irShift             = IR_RESET;
            nxt_bsrHold[OE_HI:OE_LO] = OE_RESET;
            nxt_bsrShift[OE_HI:OE_LO] = OE_RESET;
        end
        if (rise) begin
            case (state_ff)
                CIR:  nxt_irShift = IR_CAPTURE;
                SHIR: nxt_irShift = {syncB_ff.tdi, irShift_ff[IR_W-1:1]};
                CDR: begin
                    if (selBsr) begin
                        nxt_bsrShift = pinSample;
                    end else if (selId) begin
                        nxt_idShift = ID_VALUE;
                    end else begin
                        nxt_byp = 1'b0;
                    end
                end
                SHDR: begin
                    if (selBsr) begin
                        nxt_bsrShift = {syncB_ff.tdi,
                                        bsrShift_ff[BSR_W-1:1]};
                    end else if (selId) begin
                        nxt_idShift = {syncB_ff.tdi, idShift_ff[ID_W-1:1]};
                    end else begin
                        nxt_byp = syncB_ff.tdi;
                    end
                end
                default: ;
            endcase
        end
        if (fall) begin
            case (state_ff)
                SHDR, SHIR: begin
                    nxt_tdoOut  = serialOut;
                    nxt_tdoOe_n = 1'b0;
                end
                UIR: nxt_ir = irShift_ff;
                UDR: begin
                    if (selBsr) begin
                        nxt_bsrHold = bsrShift_ff;
                    end
                end
                default: nxt_tdoOe_n = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irShift_ff  <= IR_RESET;
            ir_ff       <= IR_RESET;
            bsrShift_ff <= {OE_RESET, {(BSR_W-4){1'b0}}};
            bsrHold_ff  <= {OE_RESET, {(BSR_W-4){1'b0}}};
            idShift_ff  <= '0;
            byp_ff      <= 1'b0;
            tdoOut_ff   <= 1'b0;
            tdoOe_n_ff  <= 1'b1;
        end else begin
            irShift_ff  <= nxt_irShift;
            ir_ff       <= nxt_ir;
            bsrShift_ff <= nxt_bsrShift;
            bsrHold_ff  <= nxt_bsrHold;
            idShift_ff  <= nxt_idShift;
            byp_ff      <= nxt_byp;
            tdoOut_ff   <= nxt_tdoOut;
            tdoOe_n_ff  <= nxt_tdoOe_n;
        end
    end

    // test mode takes the pins away from the transceiver
    always_comb begin
        testMode = (ir_ff == OP_EXTEST) || (ir_ff == OP_HIGHZ) ||
                   (ir_ff == OP_CLAMP);
        outFloat = (ir_ff == OP_HIGHZ);
        pinDrive = bsrHold_ff;
        scanOut.tdoOut  = tdoOut_ff;
        scanOut.tdoOe_n = tdoOe_n_ff;
        tapState = state_ff;
    end
endmodule : tap_controller

// ---- design/tap_pkg.sv ----
/*
 * Constants, state encoding and carrier types for the boundary-scan
 * test access port. Assumes the test clock is sampled by a faster
 * system clock; no software-visible registers exist.
 */
// What this block does
// - next state from mode-select at clock rise
// - sample on rise, drive outputs on fall
// - sixteen states, six stable, ten transient
// - power-up enters reset state, normal function
// - mode-select high reaches reset within five
// - reset loads instruction 10000001 (identification)
// - reset sets boundary bits 47-44 to one
// - select states idle, leave next cycle
// - capture-dr loads selected register on exit
// - shift-dr drives serial out on fall
// - shift once per cycle, not on entry
// - 8-bit instruction, 48/1/32-bit data registers
// - only one register in serial path
// - test instruction inhibits normal function
// - exit1 states float serial out on fall
// - capture-ir loads fixed 10000001 status
// - update states latch on falling edge
package tap_pkg;
    localparam int IR_W  = 8;
    localparam int BSR_W = 48;
    localparam int ID_W  = 32;
    localparam logic [IR_W-1:0] IR_RESET   = 8'h81;
    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
    localparam logic [IR_W-1:0] OP_EXTEST  = 8'h00;
    localparam logic [IR_W-1:0] OP_SAMPLE  = 8'h82;
    localparam logic [IR_W-1:0] OP_IDCODE  = 8'h81;
    localparam logic [IR_W-1:0] OP_BYPASS  = 8'hff;
    localparam logic [IR_W-1:0] OP_HIGHZ   = 8'h86;
    localparam logic [IR_W-1:0] OP_CLAMP   = 8'h87;
    localparam int OE_LO = 44;                 // output-enable cells 47..44
    localparam int OE_HI = 47;
    localparam logic [3:0] OE_RESET = 4'hf;

    typedef enum logic [3:0] {
        TLR  = 4'h0, RTI  = 4'h1, SDRS = 4'h2, CDR  = 4'h3,
        SHDR = 4'h4, E1DR = 4'h5, PDR  = 4'h6, E2DR = 4'h7,
        UDR  = 4'h8, SIRS = 4'h9, CIR  = 4'ha, SHIR = 4'hb,
        E1IR = 4'hc, PIR  = 4'hd, E2IR = 4'he, UIR  = 4'hf
    } tap_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } scan_in_t;

    typedef struct packed {
        logic tdoOut;
        logic tdoOe_n;
    } scan_out_t;
endpackage : tap_pkg

// ---- bench/tap_host_model.sv ----
/* external scan controller model: drives tck/tms/tdi, reads tdo.
   assumes clk is 20 MHz; one tck period spans about 450 ns */
`timescale 1ns/1ns
module tap_host_model
    import tap_pkg::*;
(
    input  wire logic      clk,
    output scan_in_t       scanIn,
    input  wire scan_out_t scanOut
);
    // tck idles low between frames; tms/tdi rest at pull-up level
    initial scanIn = 3'b011;

    // one tck period; inputs move only while tck is low
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clk);
        scanIn.tms <= m;
        scanIn.tdi <= d;
        repeat (4) @(posedge clk);
        scanIn.tck <= 1'b1;
        repeat (4) @(posedge clk);
        o = scanOut.tdoOe_n ? 1'bx : scanOut.tdoOut; // floating reads x
        scanIn.tck <= 1'b0;
    endtask : step
endmodule : tap_host_model

// ---- bench/tap_controller_chk.sv ----
/* concurrent checks on the scan port controller.
   assumes tck periods of at least 8 clk, as the host model makes */
`timescale 1ns/1ns
module tap_controller_chk
    import tap_pkg::*;
(
    input wire logic             clk,
    input wire logic             rst_n,
    input wire scan_in_t         scanIn,
    input wire scan_out_t        scanOut,
    input wire logic [BSR_W-1:0] pinDrive,
    input wire tap_state_t       tapState
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] hiCnt_ff;
    logic [2:0] nxt_hiCnt;
    logic       tckQ_ff;
    // run of tck rises with tms high, saturating at five
    always_comb begin
        nxt_hiCnt = hiCnt_ff;
        if (scanIn.tck && !tckQ_ff) begin
            nxt_hiCnt = !scanIn.tms ? 3'h0 : hiCnt_ff + {2'h0, hiCnt_ff != 3'h5};
        end
    end
    always_ff @(posedge clk) begin
        tckQ_ff  <= scanIn.tck;
        hiCnt_ff <= rst_n ? nxt_hiCnt : 3'h0;
    end
    a_reset_tlr: assert property ($rose(rst_n) |-> tapState == TLR)
        else $error("state not reset after release");
    a_five_high: assert property (hiCnt_ff == 3'h5 |-> ##[0:8] tapState == TLR)
        else $error("five tms highs did not reset");
    a_select_leave: assert property ($rose(tapState == SDRS) |-> ##[1:12] tapState inside {CDR, SIRS})
        else $error("select state not left");
    a_oe_benign: assert property (tapState == TLR ##1 tapState == TLR |-> pinDrive[OE_HI:OE_LO] == OE_RESET)
        else $error("enable cells not one in reset");
    a_exit_float: assert property ($rose(tapState inside {E1DR, E1IR}) |-> ##[1:12] scanOut.tdoOe_n)
        else $error("tdo not floated after exit1");
    a_idle_float: assert property (tapState == TLR [*8] |-> scanOut.tdoOe_n)
        else $error("tdo driven in reset state");
    a_state_rise: assert property (!scanIn.tck [*5] |-> $stable(tapState))
        else $error("state moved with tck low");
    a_tdo_fall: assert property (scanIn.tck [*4] |-> $stable(scanOut))
        else $error("tdo moved with tck high");
    cover property (tapState == SHDR ##1 tapState == E1DR);
    cover property (tapState == UIR);
    cover property (tapState == SHIR [*8]);
endmodule : tap_controller_chk

// ---- bench/tb.sv ----
/* self-checking bench for the scan port controller.
   assumes the host model paces tck; pins are driven by the bench */
`timescale 1ns/1ns
module tb;
    import tap_pkg::*;
    localparam logic [ID_W-1:0] ID_ARB = 32'h5a3c_0f01; // arbitrary value
    localparam logic [47:0] PINS = 48'hc3a5_0f96_1e2d;
    logic             clk;
    logic             rst_n;
    scan_in_t         scanIn;
    scan_out_t        scanOut;
    logic [BSR_W-1:0] pinSample;
    logic [BSR_W-1:0] pinDrive;
    logic             testMode;
    logic             outFloat;
    tap_state_t       tapState;
    logic [47:0]      d;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    tap_controller #(.ID_VALUE(ID_ARB)) i_tap_controller (.clk(clk),
        .rst_n(rst_n), .scanIn(scanIn), .scanOut(scanOut),
        .pinSample(pinSample), .pinDrive(pinDrive), .testMode(testMode),
        .outFloat(outFloat), .tapState(tapState));
    tap_host_model host (.clk(clk), .scanIn(scanIn), .scanOut(scanOut));

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic mv(input int n, input logic m);
        logic o;
        repeat (n) host.step(m, 1'b1, o);
        repeat (2) @(posedge clk); // state lags the tck rise
    endtask : mv
    // full scan from idle back to idle, lsb first
    task automatic scan(input logic ir, input int w, input logic [47:0] din);
        logic o;
        d = '0;
        mv(1 + ir, 1'b1);
        mv(2, 1'b0);
        for (int i = 0; i < w; i++) begin
            host.step(i == w - 1, din[i], o);
            d[i] = o;
        end
        mv(1, 1'b1);
        mv(1, 1'b0);
    endtask : scan
    task automatic end_sim;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic t_basic;
        chk(tapState, TLR);
        chk(pinDrive[OE_HI:OE_LO], OE_RESET);
        chk({testMode, scanOut.tdoOe_n}, 2'b01);
        mv(1, 1'b0);
        chk(tapState, RTI);
        scan(1'b1, 8, OP_BYPASS);
        chk(d[7:0], IR_CAPTURE);
        scan(1'b0, 4, 48'h5);
        chk(d[3:0], 4'ha);
        $display("test basic done");
    endtask : t_basic
    // abort in mid-shift, then identification from reset
    task automatic t_ident;
        mv(1, 1'b1);
        mv(2, 1'b0);
        mv(5, 1'b1);
        chk(tapState, TLR);
        mv(1, 1'b0);
        scan(1'b0, 32, 48'h0);
        chk(d[31:0], ID_ARB);
        $display("test ident done");
    endtask : t_ident
    task automatic t_extest;
        pinSample <= PINS;
        scan(1'b1, 8, OP_EXTEST);
        chk(testMode, 1'b1);
        scan(1'b0, 48, 48'h5555_aaaa_1234);
        chk(d, PINS);
        chk(pinDrive, 48'h5555_aaaa_1234);
        scan(1'b1, 8, OP_CLAMP);
        chk({testMode, outFloat}, 2'b10);
        scan(1'b0, 2, 48'h3);
        chk(d[1:0], 2'h2);
        scan(1'b1, 8, OP_SAMPLE);
        chk(testMode, 1'b0);
        scan(1'b0, 48, 48'h0);
        chk(d, PINS);
        scan(1'b1, 8, OP_HIGHZ);
        chk({testMode, outFloat}, 2'b11);
        mv(5, 1'b1);
        chk(testMode, 1'b0);
        $display("test extest done");
    endtask : t_extest

    // 50 ns system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // cut a hang well past the roughly 2300 clk the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        rst_n = 1'b0;
        pinSample = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_basic();
        t_ident();
        t_extest();
        end_sim();
    end
endmodule : tb

bind tap_controller tap_controller_chk i_chk (.clk(clk), .rst_n(rst_n),
    .scanIn(scanIn), .scanOut(scanOut), .pinDrive(pinDrive),
    .tapState(tapState));
